// ==== rtl/shp_regs.vh ====
// Constants of the host port: strap codes, register indices and FIFO sizing.
// Function
// - Strap selects bus arrangement: 0 single shared bus, 1 split bus.
// - In arrangement 1 processor port serves register access concurrently with DMA.
// - Command, scratch and FIFO registers are readable and writable; status and count are read-only.
// - All DMA moves eight bits per transfer on the shared data lines.
// - One parity bit travels with each byte on the data port.
// - DMA direction comes from the current command, not the controller.
// - Inbound DMA data is captured on the write strobe.
// - Outbound DMA data is driven only under acknowledge; in arrangement 0 register reads drive the data port without it.
// - A 16-byte FIFO buffers data between SCSI and host sides.
// - Protocol sequences run without processor accesses in between.
`ifndef SHP_REGS_VH
`define SHP_REGS_VH
`define SHP_MODE_SINGLE 1'b0
`define SHP_MODE_SPLIT  1'b1
`define SHP_REG_FIFO    4'h2
`define SHP_REG_CMD     4'h3
`define SHP_REG_STAT    4'h4
`define SHP_REG_SCRATCH 4'h5
`define SHP_REG_COUNT   4'h6
`define SHP_CMD_RST     8'h00
`define SHP_CMD_DIR_BIT 7
`define SHP_FIFO_DEPTH  16
`define SHP_FIFO_AW     4
`endif

// ==== rtl/shp_fifo.v ====
// Byte FIFO with parity that sits between the SCSI side and the host side.
`timescale 1ns/1ps
module shp_fifo #(
   parameter DEPTH = 16,
   parameter AW    = 4
) (
   input  wire          i_ref_clk,  // Chip clock.
   input  wire          i_reset_n,  // Synchronous reset, active low.
   input  wire          i_clear,    // Empties the FIFO.
   input  wire          i_push,     // Write one entry.
   input  wire [8:0]    i_wdata,    // Byte with parity in bit 8.
   input  wire          i_pop,      // Remove the head entry.
   output wire [8:0]    o_rdata,    // Head entry.
   output wire          o_full,     // No room left.
   output wire          o_empty,    // Nothing stored.
   output wire [AW:0]   o_count     // Entries held.
);
   reg [8:0]  mem [0:DEPTH-1];
   reg [AW-1:0] wp_q;
   reg [AW-1:0] rp_q;
   reg [AW:0]   cnt_q;
   wire         do_push;
   wire         do_pop;
   // Count value that means every entry is in use.
   localparam [AW:0] FULL_CNT = DEPTH;

   // Push is refused when full and pop when empty.
   assign do_push = i_push && (cnt_q != FULL_CNT);
   assign do_pop  = i_pop && (cnt_q != {(AW+1){1'b0}});
   assign o_rdata = mem[rp_q];
   assign o_full  = (cnt_q == FULL_CNT);
   assign o_empty = (cnt_q == {(AW+1){1'b0}});
   assign o_count = cnt_q;

   // Storage array write port.
   always @(posedge i_ref_clk) begin
      if (do_push) begin
         mem[wp_q] <= i_wdata;
      end
   end

   // Pointer and count bookkeeping.
   always @(posedge i_ref_clk) begin
      if (!i_reset_n || i_clear) begin
         wp_q  <= {AW{1'b0}};
         rp_q  <= {AW{1'b0}};
         cnt_q <= {(AW+1){1'b0}};
      end else begin
         if (do_push) begin
            wp_q <= wp_q + 1'b1;
         end
         if (do_pop) begin
            rp_q <= rp_q + 1'b1;
         end
         if (do_push && !do_pop) begin
            cnt_q <= cnt_q + 1'b1;
         end else if (do_pop && !do_push) begin
            cnt_q <= cnt_q - 1'b1;
         end
      end
   end
endmodule

// ==== rtl/shp_host_port.v ====
// Host bus port: processor register access, DMA data port and data FIFO.
`timescale 1ns/1ps
`include "shp_regs.vh"
module shp_host_port #(
   parameter DEPTH = `SHP_FIFO_DEPTH,
   parameter AW    = `SHP_FIFO_AW
) (
   input  wire        i_ref_clk,        // Chip clock, 25 MHz.
   input  wire        i_reset_n,        // Synchronous reset, active low.
   input  wire        i_mode_strap,     // Bus arrangement strap pin.
   input  wire        i_dma_ack_n,      // DMA acknowledge, active low.
   input  wire        i_dma_wr_n,       // DMA write strobe, active low.
   input  wire        i_dma_rd_n,       // DMA read strobe, active low.
   input  wire [7:0]  i_dma_data_lines, // Data port lines in.
   input  wire        i_dma_parity_bit, // Data port parity in.
   output reg  [7:0]  o_dma_data_lines, // Data port lines out.
   output reg         o_dma_parity_bit, // Data port parity out.
   output wire        o_dma_oe,         // Data port drive enable.
   input  wire        i_cs_n,           // Register select, active low.
   input  wire        i_rd_n,           // Register read strobe, active low.
   input  wire        i_wr_n,           // Register write strobe, active low.
   input  wire [3:0]  i_addr,           // Register index.
   input  wire [7:0]  i_pad_data,       // Processor port data in.
   output reg  [7:0]  o_pad_data,       // Processor port data out.
   output wire        o_pad_oe,         // Processor port drive enable.
   output reg         o_dma_req,        // DMA request, active high.
   input  wire        i_scsi_push,      // SCSI side writes a byte.
   input  wire [8:0]  i_scsi_wdata,     // SCSI byte with parity.
   input  wire        i_scsi_pop,       // SCSI side takes a byte.
   output wire [8:0]  o_scsi_rdata,     // FIFO head for the SCSI side.
   output wire        o_fifo_full,      // FIFO full.
   output wire        o_fifo_empty,     // FIFO empty.
   output wire [7:0]  o_command,        // Command for the sequencer.
   output reg         o_cmd_strobe,     // One-cycle pulse on a command write.
   output reg         o_mode            // Latched bus arrangement.
);
   // Width of the pin vector that passes the synchronisers.
   localparam NPIN = 28;
   wire [NPIN-1:0] pin_raw;    // Pins before synchronising.
   wire [NPIN-1:0] pin_sync;   // Pins after two flip-flops.
   reg  [7:0]      cmd_q;      // Executing command.
   reg  [7:0]      scratch_q;  // Scratch register.
   reg             wr_old_q;   // Previous DMA write strobe.
   reg             rd_old_q;   // Previous DMA read strobe.
   reg             pwr_old_q;  // Previous processor write strobe.
   reg             prd_old_q;  // Previous processor read strobe.
   reg             rst_seen_q; // High in reset and one cycle after.
   wire            ack;        // Synchronised acknowledge.
   wire            wr_l;       // Synchronised DMA write strobe.
   wire            rd_l;       // Synchronised DMA read strobe.
   wire            cs;         // Synchronised register select.
   wire            prd_l;      // Synchronised processor read strobe.
   wire            pwr_l;      // Synchronised processor write strobe.
   wire            strap_s;    // Synchronised strap.
   wire [3:0]      addr_s;     // Synchronised register index.
   wire [7:0]      pad_s;      // Synchronised processor data.
   wire [7:0]      lines_s;    // Synchronised data port lines.
   wire            par_s;      // Synchronised data port parity.
   genvar          gi;
   wire       dir_out;
   wire       dma_wr_rise, dma_rd_rise;
   wire       reg_wr, reg_rd, reg_sel;
   wire [7:0] reg_wdata;
   wire       dma_push, dma_pop, reg_push, reg_pop;
   wire [8:0] head;
   wire [AW:0] count;
   reg  [7:0] rd_mux;

   // Raw pins; active-low strobes are inverted so that 1 means asserted.
   assign pin_raw = {~i_dma_ack_n, ~i_dma_wr_n, ~i_dma_rd_n, ~i_cs_n,
                     ~i_rd_n, ~i_wr_n, i_mode_strap, i_addr, i_pad_data,
                     i_dma_data_lines, i_dma_parity_bit};

   // Two flip-flops per pin bit; logic reads only the second stage, so
   // data and index arrive together with the strobes that qualify them.
   generate
      for (gi = 0; gi < NPIN; gi = gi + 1) begin : g_sync
         reg meta_q;
         reg sync_q;
         always @(posedge i_ref_clk) begin
            meta_q <= pin_raw[gi];
            sync_q <= meta_q;
         end
         assign pin_sync[gi] = sync_q;
      end
   endgenerate

   // Named views of the synchronised pins.
   assign ack     = pin_sync[27];
   assign wr_l    = pin_sync[26];
   assign rd_l    = pin_sync[25];
   assign cs      = pin_sync[24];
   assign prd_l   = pin_sync[23];
   assign pwr_l   = pin_sync[22];
   assign strap_s = pin_sync[21];
   assign addr_s  = pin_sync[20:17];
   assign pad_s   = pin_sync[16:9];
   assign lines_s = pin_sync[8:1];
   assign par_s   = pin_sync[0];

   // Strap is caught while reset is held, then stays fixed.
   always @(posedge i_ref_clk) begin
      if (!i_reset_n) begin
         o_mode     <= strap_s;
         rst_seen_q <= 1'b1;
      end else begin
         rst_seen_q <= 1'b0;
      end
   end

   // Trailing-edge detectors on the synchronised strobes.
   always @(posedge i_ref_clk) begin
      wr_old_q  <= wr_l;
      rd_old_q  <= rd_l;
      pwr_old_q <= pwr_l;
      prd_old_q <= prd_l;
   end
   assign dma_wr_rise = wr_old_q && !wr_l;
   assign dma_rd_rise = rd_old_q && !rd_l;

   // Direction follows the executing command.
   assign dir_out = cmd_q[`SHP_CMD_DIR_BIT];

   // Register cycles: processor port in split mode, data port otherwise.
   // In single mode a select without acknowledge is a register cycle; the
   // processor has already won the shared bus.
   assign reg_sel = cs && (o_mode == `SHP_MODE_SPLIT || !ack);
   assign reg_wr  = reg_sel && (o_mode == `SHP_MODE_SPLIT ?
                    (pwr_old_q && !pwr_l) : dma_wr_rise);
   assign reg_rd  = reg_sel && (o_mode == `SHP_MODE_SPLIT ?
                    (prd_old_q && !prd_l) : dma_rd_rise);
   assign reg_wdata = (o_mode == `SHP_MODE_SPLIT) ? pad_s : lines_s;

   // DMA moves bytes with parity only under acknowledge.
   assign dma_push = ack && !dir_out && dma_wr_rise;
   assign dma_pop  = ack && dir_out && dma_rd_rise;
   assign reg_push = reg_wr && (addr_s == `SHP_REG_FIFO);
   assign reg_pop  = reg_rd && (addr_s == `SHP_REG_FIFO);

   // Host-side FIFO access and SCSI-side access share one store.
   shp_fifo #(.DEPTH(DEPTH), .AW(AW)) u_fifo (
      .i_ref_clk (i_ref_clk),
      .i_reset_n (i_reset_n),
      .i_clear   (1'b0),
      .i_push    (dma_push || reg_push || i_scsi_push),
      .i_wdata   (i_scsi_push ? i_scsi_wdata :
                  (dma_push ? {par_s, lines_s}
                            : {~^reg_wdata, reg_wdata})),
      .i_pop     (dma_pop || reg_pop || i_scsi_pop),
      .o_rdata   (head),
      .o_full    (o_fifo_full),
      .o_empty   (o_fifo_empty),
      .o_count   (count)
   );
   assign o_scsi_rdata = head;

   // Command and scratch registers; a command write starts a sequence.
   always @(posedge i_ref_clk) begin
      if (!i_reset_n) begin
         cmd_q        <= `SHP_CMD_RST;
         scratch_q    <= 8'h00;
         o_cmd_strobe <= 1'b0;
      end else begin
         o_cmd_strobe <= 1'b0;
         if (reg_wr && addr_s == `SHP_REG_CMD) begin
            cmd_q        <= reg_wdata;
            o_cmd_strobe <= 1'b1;
         end
         if (reg_wr && addr_s == `SHP_REG_SCRATCH) begin
            scratch_q <= reg_wdata;
         end
      end
   end
   assign o_command = cmd_q;

   // Register read multiplexer.
   always @* begin
      case (addr_s)
         `SHP_REG_FIFO:    rd_mux = head[7:0];
         `SHP_REG_CMD:     rd_mux = cmd_q;
         `SHP_REG_STAT:    rd_mux = {5'h00, o_mode, o_fifo_full,
                                     o_fifo_empty};
         `SHP_REG_SCRATCH: rd_mux = scratch_q;
         `SHP_REG_COUNT:   rd_mux = {{(7-AW){1'b0}}, count};
         default:          rd_mux = 8'h00;
      endcase
   end

   // Output data registers and request line.
   always @(posedge i_ref_clk) begin
      if (!i_reset_n) begin
         o_dma_data_lines <= 8'h00;
         o_dma_parity_bit <= 1'b0;
         o_pad_data       <= 8'h00;
         o_dma_req        <= 1'b0;
      end else begin
         if (ack && dir_out) begin
            o_dma_data_lines <= head[7:0];
            o_dma_parity_bit <= head[8];
         end else if (o_mode == `SHP_MODE_SINGLE) begin
            o_dma_data_lines <= rd_mux;
            o_dma_parity_bit <= ~^rd_mux;
         end
         o_pad_data <= rd_mux;
         o_dma_req  <= dir_out ? !o_fifo_empty : !o_fifo_full;
      end
   end

   // Drive enables: DMA reads under acknowledge, register reads on select.
   assign o_dma_oe = !rst_seen_q && ((ack && dir_out) ||
                     (o_mode == `SHP_MODE_SINGLE && cs && !ack && rd_l));
   assign o_pad_oe = !rst_seen_q && o_mode == `SHP_MODE_SPLIT && cs && prd_l;
endmodule

// ==== verif/shp_host_port_checker.sv ====
// Concurrent checks on the pins of the host port.
`timescale 1ns/1ps
module shp_host_port_checker (
   input wire       i_ref_clk, i_reset_n, i_mode_strap, // Clock, strap.
   input wire       i_dma_ack_n, i_dma_wr_n, o_dma_oe,  // Data port.
   input wire       o_pad_oe, o_dma_req, o_fifo_empty,  // Pad and FIFO.
   input wire [7:0] o_command,                          // Command.
   input wire       o_cmd_strobe, o_mode                // Pulse, mode.
);
   default clocking cb @(posedge i_ref_clk); endclocking
   default disable iff (!i_reset_n);
   // Arrangement latch and drive enables.
   AST_MODE_LATCH: assert property ($rose(i_reset_n)
      |-> o_mode == $past(i_mode_strap)) else $error("mode not latched");
   AST_MODE_HELD: assert property ($past(i_reset_n)
      |-> $stable(o_mode)) else $error("mode changed");
   AST_OE_ACK: assert property ((o_mode && i_dma_ack_n) [*3]
      |=> !o_dma_oe) else $error("data port driven without ack");
   AST_PAD_SPLIT: assert property (o_pad_oe |-> o_mode)
      else $error("pad driven in single mode");
   // Request, command pulse and DMA capture.
   AST_REQ_OUT: assert property ((o_command[7] && !o_fifo_empty) [*2]
      |-> o_dma_req) else $error("no request with data to send");
   AST_CMD_PULSE: assert property (o_cmd_strobe |=> !o_cmd_strobe)
      else $error("command pulse too long");
   AST_WR_TAKEN: assert property ($rose(i_dma_wr_n) && !i_dma_ack_n
      && !o_command[7] && o_fifo_empty |-> ##[1:6] !o_fifo_empty)
      else $error("dma write not captured");
   AST_WR_IGNORED: assert property ($rose(i_dma_wr_n) && o_command[7]
      && o_fifo_empty |-> o_fifo_empty [*6]) else $error("write taken");
   COV_DMA_IN: cover property ($rose(i_dma_wr_n) && !i_dma_ack_n);
   COV_DMA_OUT: cover property ($rose(o_dma_oe));
   COV_PAD_READ: cover property ($rose(o_pad_oe));
endmodule
// Attaches the checker to every host port instance.
bind shp_host_port shp_host_port_checker shp_host_port_checker_i (.*);

// ==== verif/shp_dma_model.sv ====
// Behavioural DMA controller on the data port.
`timescale 1ns/1ps
module shp_dma_model (
   input  wire        i_clk,           // Chip clock.
   input  wire  [9:0] i_dev,           // Device enable, parity, data.
   output logic       o_ack_n = 1'b1,  // Acknowledge, active low.
   output logic       o_wr_n = 1'b1,   // Write strobe, active low.
   output logic       o_rd_n = 1'b1,   // Read strobe, active low.
   output logic [8:0] o_dq = 9'h155    // Parity and data out.
);
   // One access: ack low throughout, strobe low for five edges.
   task automatic xfer(input logic wr, input logic [8:0] wv,
                       output logic [9:0] rv);
      {o_ack_n, o_wr_n, o_rd_n} = {1'b0, !wr, wr};
      o_dq = wr ? wv : ~o_dq;
      repeat (5) @(posedge i_clk);
      #1 rv = i_dev;
      {o_wr_n, o_rd_n} = 2'b11;
      repeat (4) @(posedge i_clk);
      #1 {o_ack_n, o_dq} = {1'b1, ~o_dq};
      repeat (3) @(posedge i_clk);
      #1;
   endtask
endmodule

// ==== verif/tb.sv ====
// Self-checking bench of the host port with a DMA controller model.
`timescale 1ns/1ps
module tb;
   logic        i_ref_clk = 1'b0, i_reset_n = 1'b0, i_mode_strap = 1'b1;
   logic        i_cs_n = 1'b1, i_rd_n = 1'b1, i_wr_n = 1'b1;
   logic        i_scsi_push = 1'b0, i_scsi_pop = 1'b0;
   logic [3:0]  i_addr = 4'h0;
   logic [7:0]  i_pad_data = 8'h00, rd;
   logic [8:0]  i_scsi_wdata = 9'h0a7;
   logic [9:0]  rv;
   wire  [7:0]  i_dma_data_lines, o_dma_data_lines, o_pad_data, o_command;
   wire  [8:0]  dq, o_scsi_rdata;
   wire         i_dma_ack_n, i_dma_wr_n, i_dma_rd_n, i_dma_parity_bit;
   wire         o_dma_parity_bit, o_dma_oe, o_pad_oe, o_dma_req, o_mode;
   wire         o_fifo_full, o_fifo_empty, o_cmd_strobe;
   int          errors = 0, checks_done = 0;
   // Register cycles as {write, index, write data, expected read data}.
   logic [23:0] rows [0:8] = '{24'h155a00, 24'h05005a, 24'h0f0000,
      24'h138000, 24'h040005, 24'h123c00, 24'h060001, 24'h02003c,
      24'h060000};
   assign {i_dma_parity_bit, i_dma_data_lines} = dq;
   // Chip clock with a 40 ns period.
   always #20 i_ref_clk = ~i_ref_clk;
   shp_host_port shp_host_port_i (.*);
   shp_dma_model shp_dma_model_i (.i_clk(i_ref_clk), .o_dq(dq),
      .i_dev({o_dma_oe, o_dma_parity_bit, o_dma_data_lines}),
      .o_ack_n(i_dma_ack_n), .o_wr_n(i_dma_wr_n), .o_rd_n(i_dma_rd_n));
   // Lets n edges pass and settles just after the last one.
   task automatic tick(input int n);
      repeat (n) @(posedge i_ref_clk);
      #1;
   endtask
   // Processor port cycle; select is held past the strobe release.
   task automatic reg_acc(input logic wr, input logic [3:0] a,
                          input logic [7:0] wd);
      {i_cs_n, i_wr_n, i_rd_n, i_addr, i_pad_data} = {1'b0, !wr, wr, a, wd};
      tick(5);
      rd = o_pad_data;
      {i_wr_n, i_rd_n} = 2'b11;
      tick(4);
      i_cs_n = 1'b1;
      tick(2);
   endtask
   // Compares a seen value with the expected one; counts every check and each mismatch.
   task automatic chk(input logic [9:0] seen, exp);
      checks_done++;
      if (seen !== exp) begin
         errors++;
         $display("[ERR] %0t seen %h want %h", $time, seen, exp);
      end
   endtask
   // Prints the counts and the verdict, then stops the run.
   task automatic results;
      $display("checks %0d errors %0d", checks_done, errors);
      if (errors == 0 && checks_done > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   // Reset, register table, DMA both ways, second reset and fill.
   initial begin
      tick(4);
      {i_reset_n, i_mode_strap} = 2'b10;
      tick(3);
      chk({o_mode, o_dma_oe, 8'h00}, 10'h200);
      $display("reset test done");
      for (int k = 0; k < 9; k++) begin
         reg_acc(rows[k][20], rows[k][19:16], rows[k][15:8]);
         if (!rows[k][20]) chk(10'(rd), 10'(rows[k][7:0]));
      end
      $display("register table done");
      reg_acc(1'b1, 4'h3, 8'h00);
      shp_dma_model_i.xfer(1'b1, 9'h16b, rv);
      chk({1'b0, o_scsi_rdata}, 10'h16b);
      reg_acc(1'b1, 4'h3, 8'h80);
      chk({9'h000, o_dma_req}, 10'h001);
      shp_dma_model_i.xfer(1'b0, 9'h000, rv);
      chk(rv, 10'h36b);
      shp_dma_model_i.xfer(1'b1, 9'h0f0, rv);
      chk({o_dma_oe, 8'h00, o_fifo_empty}, 10'h001);
      $display("dma test done");
      i_reset_n = 1'b0;
      tick(4);
      {i_reset_n, i_scsi_push} = 2'b11;
      tick(17);
      i_scsi_push = 1'b0;
      tick(2);
      chk({o_mode, 7'h00, o_fifo_full, o_dma_req}, 10'h002);
      i_scsi_pop = 1'b1;
      tick(16);
      i_scsi_pop = 1'b0;
      tick(2);
      chk({o_fifo_empty, 8'h00, o_dma_req}, 10'h201);
      $display("strap and fill test done");
      results();
   end
endmodule
